// ===== adc_out_defs.svh
// Constants of the converter output stage
`ifndef ADC_OUT_DEFS_SVH
`define ADC_OUT_DEFS_SVH
`define CODE_WIDTH 8
`define CODE_ALL_ONES 8'hff
`define CODE_ALL_ZEROS 8'h00
`define CODE_RESET 8'h00
`define FLAG_RESET 1'b0
`define VALID_EDGE_COUNT 2'h2
`define CLK_MAX_MHZ 75
`define REF_CLK_MHZ 125
`endif

// ===== adc_out_pkg.sv
// Types of the converter output stage
package adc_out_pkg;
  typedef logic [7:0] code_t;
  typedef enum logic [1:0]
  {
    RANGE_IN = 2'b01,
    RANGE_OUT = 2'b10
  } range_t;
endpackage : adc_out_pkg

// ===== sample_classify.sv
// Saturation and range classification of one raw sample
`timescale 1ns/10ps
`include "adc_out_defs.svh"
module sample_classify
(
  input wire adc_out_pkg::code_t raw_code_i,
  input wire logic above_top_i,
  input wire logic below_bottom_i,
  output adc_out_pkg::code_t code_o,
  output logic range_flag_o
);
  import adc_out_pkg::*;

  always_comb
  begin
    code_o = raw_code_i;
    if (above_top_i)
    begin
      code_o = `CODE_ALL_ONES;
    end
    else if (below_bottom_i)
    begin
      code_o = `CODE_ALL_ZEROS;
    end
    range_flag_o = above_top_i | below_bottom_i;
  end
endmodule : sample_classify

// ===== adc_sample_output_stage.sv
// Output stage: sample capture, output latch, float control
// Summary of operation
// - Float request high floats the code bus
// - Low drives code and flag; high floats both
// - Works from stopped clock up to 75 MHz
// - Data valid from second edge after restart
// - Flag high when input outside the references
// - Above top reference code is all ones
// - Below bottom reference code is all zeros
// - Sample taken on the rising clock edge
// - Output word lags its sample one cycle
// - Eight-bit straight binary, bit seven MSB
`timescale 1ns/10ps
`include "adc_out_defs.svh"
module adc_sample_output_stage
#(
  parameter int CODE_W = `CODE_WIDTH
)
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sample_tick_i,
  input wire adc_out_pkg::code_t raw_code_i,
  input wire logic above_top_i,
  input wire logic below_bottom_i,
  input wire logic output_float_request_i,
  output adc_out_pkg::code_t sample_code_o,
  output logic sample_code_oe_o,
  output logic range_flag_o,
  output logic range_flag_oe_o,
  output logic data_valid_o
);
  import adc_out_pkg::*;

  typedef struct packed
  {
    logic [1:0] float_sync;
    logic [1:0] ovr_sync;
    logic [1:0] und_sync;
    code_t cap_code;
    logic cap_flag;
    code_t out_code;
    logic out_flag;
    logic [1:0] edge_cnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  code_t cls_code;
  logic cls_flag;

  // Raw sample is taken as a bus word from converter logic on this clock
  sample_classify sample_classify_inst
  (
    .raw_code_i(raw_code_i),
    .above_top_i(s_q.ovr_sync[1]),
    .below_bottom_i(s_q.und_sync[1]),
    .code_o(cls_code),
    .range_flag_o(cls_flag)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.float_sync = {s_q.float_sync[0], output_float_request_i};
    s_d.ovr_sync = {s_q.ovr_sync[0], above_top_i};
    s_d.und_sync = {s_q.und_sync[0], below_bottom_i};
    if (sample_tick_i)
    begin
      // Capture on sampling edge, present on the next one
      s_d.cap_code = cls_code;
      s_d.cap_flag = cls_flag;
      s_d.out_code = s_q.cap_code;
      s_d.out_flag = s_q.cap_flag;
      // Validity counts edges since the first one after a stop
      if (s_q.edge_cnt != `VALID_EDGE_COUNT)
      begin
        s_d.edge_cnt = s_q.edge_cnt + 2'h1;
      end
    end
    else
    begin
      // Stopped sampling clock: restart counts anew
      s_d.edge_cnt = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '{float_sync: 2'h3, ovr_sync: 2'h0, und_sync: 2'h0,
               cap_code: `CODE_RESET, cap_flag: `FLAG_RESET,
               out_code: `CODE_RESET, out_flag: `FLAG_RESET,
               edge_cnt: 2'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sample_code_o = s_q.out_code;
  assign range_flag_o = s_q.out_flag;
  assign sample_code_oe_o = ~s_q.float_sync[1];
  assign range_flag_oe_o = ~s_q.float_sync[1];
  assign data_valid_o = (s_q.edge_cnt == `VALID_EDGE_COUNT);

  property p_float_both;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_code_oe_o == range_flag_oe_o;
  endproperty
  a_float_both: assert property (p_float_both)
    else $error("code and flag enables differ");

  property p_float_follow;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      output_float_request_i [*3] |-> !sample_code_oe_o;
  endproperty
  a_float_follow: assert property (p_float_follow)
    else $error("bus driven while float requested");

  property p_drive_follow;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !output_float_request_i [*3] |-> sample_code_oe_o && range_flag_oe_o;
  endproperty
  a_drive_follow: assert property (p_drive_follow)
    else $error("bus floated while drive requested");

  sequence s_two_ticks;
    !sample_tick_i ##1 sample_tick_i [*2];
  endsequence
  property p_valid_second;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_two_ticks |=> data_valid_o;
  endproperty
  a_valid_second: assert property (p_valid_second)
    else $error("data not valid after second edge");

  property p_not_valid_first;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !sample_tick_i ##1 sample_tick_i |=> !data_valid_o;
  endproperty
  a_not_valid_first: assert property (p_not_valid_first)
    else $error("data valid after only one edge");

  property p_latency;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_tick_i ##1 sample_tick_i |=>
        sample_code_o == $past(cls_code, 2);
  endproperty
  a_latency: assert property (p_latency)
    else $error("output word not one sample late");

  property p_flag_pair;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_tick_i ##1 sample_tick_i |=>
        range_flag_o == $past(cls_flag, 2);
  endproperty
  a_flag_pair: assert property (p_flag_pair)
    else $error("flag not aligned with its code");

  property p_sat_high;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_q.ovr_sync[1] |-> cls_code == `CODE_ALL_ONES && cls_flag;
  endproperty
  a_sat_high: assert property (p_sat_high)
    else $error("overrange code not all ones");

  property p_sat_low;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_q.und_sync[1] && !s_q.ovr_sync[1] |->
        cls_code == `CODE_ALL_ZEROS && cls_flag;
  endproperty
  a_sat_low: assert property (p_sat_low)
    else $error("underrange code not all zeros");

  property p_in_range;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !s_q.und_sync[1] && !s_q.ovr_sync[1] |->
        cls_code == raw_code_i && !cls_flag;
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("in-range sample altered or flagged");

  // Overrange sample followed by the tick that presents it
  sequence s_over_pair;
    (sample_tick_i && s_q.ovr_sync[1]) ##1 sample_tick_i;
  endsequence

  property p_sat_high_out;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_over_pair |=> sample_code_o == `CODE_ALL_ONES && range_flag_o;
  endproperty
  a_sat_high_out: assert property (p_sat_high_out)
    else $error("overrange word not all ones at output");

  // Underrange sample followed by the tick that presents it
  sequence s_under_pair;
    (sample_tick_i && s_q.und_sync[1] && !s_q.ovr_sync[1]) ##1
      sample_tick_i;
  endsequence

  property p_sat_low_out;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_under_pair |=> sample_code_o == `CODE_ALL_ZEROS && range_flag_o;
  endproperty
  a_sat_low_out: assert property (p_sat_low_out)
    else $error("underrange word not all zeros at output");

  property p_flag_code;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      range_flag_o |->
        sample_code_o == `CODE_ALL_ONES || sample_code_o == `CODE_ALL_ZEROS;
  endproperty
  a_flag_code: assert property (p_flag_code)
    else $error("flagged word is not saturated");

  property p_idle_invalid;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !sample_tick_i |=> !data_valid_o;
  endproperty
  a_idle_invalid: assert property (p_idle_invalid)
    else $error("data valid kept across a stopped clock");

  property p_idle_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !sample_tick_i |=> $stable(sample_code_o) && $stable(range_flag_o);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("output word moved without a tick");

  property p_valid_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_tick_i && data_valid_o |=> data_valid_o;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("data valid dropped while ticks continue");
endmodule : adc_sample_output_stage

// ===== adc_word_sink.sv
// Downstream logic capturing parallel sample words
`timescale 1ns/10ps
module adc_word_sink
(
  input wire logic ref_clk_i,
  input wire adc_out_pkg::code_t code_i,
  input wire logic code_oe_i,
  input wire logic flag_i,
  input wire logic flag_oe_i,
  input wire logic valid_i,
  output adc_out_pkg::code_t bus_o,
  output logic flag_bus_o,
  output adc_out_pkg::code_t word_o
);
  import adc_out_pkg::*;

  // Floated lines show the inverse of the current stage output code and flag
  assign bus_o = code_oe_i ? code_i : ~code_i;
  assign flag_bus_o = flag_oe_i ? flag_i : ~flag_i;
  // Words kept only once data is valid
  always @(posedge ref_clk_i) if (valid_i) word_o <= bus_o;
endmodule : adc_word_sink

// ===== test_adc_sample_output_stage.sv
// Random and corner stimulus for the converter output stage
`timescale 1ns/10ps
`include "adc_out_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_adc_sample_output_stage;
  import adc_out_pkg::*;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, tick = 1'b0;
  logic above = 1'b0, below = 1'b0, flt = 1'b0, pend_f = 1'b0, exp_f = 1'b0;
  logic code_oe, flag, flag_oe, valid, fbus;
  // Float request as the bus shows it, two edges on
  logic [1:0] fq = 2'h3;
  code_t raw = 8'h00, code, bus, word, pend_c = 8'h00, exp_c = 8'h00;
  int miscompares = 0, n_checks = 0, seed = 4682;
  always #4 ref_clk_i = ~ref_clk_i;
  adc_sample_output_stage adc_sample_output_stage_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sample_tick_i(tick),
    .raw_code_i(raw), .above_top_i(above), .below_bottom_i(below),
    .output_float_request_i(flt), .sample_code_o(code),
    .sample_code_oe_o(code_oe), .range_flag_o(flag),
    .range_flag_oe_o(flag_oe), .data_valid_o(valid));
  adc_word_sink adc_word_sink_inst (
    .ref_clk_i(ref_clk_i), .code_i(code), .code_oe_i(code_oe),
    .flag_i(flag), .flag_oe_i(flag_oe), .valid_i(valid), .bus_o(bus),
    .flag_bus_o(fbus), .word_o(word));
  function automatic code_t cls(code_t r, logic a, logic b);
    return a ? `CODE_ALL_ONES : (b ? `CODE_ALL_ZEROS : r);
  endfunction : cls
  task automatic cyc(input logic t, input code_t r);
    tick = t;
    raw = r;
    @(posedge ref_clk_i);
    #1;
    fq = {fq[0], flt};
    if (t)
    begin
      exp_c = pend_c;
      exp_f = pend_f;
      pend_c = cls(r, above, below);
      pend_f = above | below;
    end
    `CHK("code_oe", ~fq[1], code_oe)
    `CHK("flag_oe", ~fq[1], flag_oe)
    if (!fq[1])
    begin
      `CHK("code", exp_c, bus)
      `CHK("flag", exp_f, fbus)
    end
  endtask : cyc
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    repeat (3) cyc(1'b0, 8'h00);
    for (int g = 0; g < 8; g++)
    begin
      above = g[0];
      below = g[1];
      repeat (3) cyc(1'b0, code_t'($random(seed)));
      `CHK("valid_idle", 1'b0, valid)
      for (int j = 0; j < 7; j++)
        cyc(1'b1, j == 1 ? 8'hff : (j == 2 ? 8'h00 : code_t'($random(seed))));
      `CHK("valid_run", 1'b1, valid)
      flt = g[2];
      repeat (3) cyc(1'b0, 8'h5a);
      `CHK("code_oe", ~flt, code_oe)
      `CHK("flag_oe", ~flt, flag_oe)
      flt = 1'b0;
      repeat (3) cyc(1'b0, 8'h00);
      `CHK("word", exp_c, word)
    end
    // Random ticks and float requests, range levels steady
    above = 1'b0;
    below = 1'b0;
    repeat (3) cyc(1'b0, 8'h00);
    repeat (200)
    begin
      flt = 1'($random(seed));
      cyc(1'($random(seed)), code_t'($random(seed)));
    end
    flt = 1'b0;
    repeat (3) cyc(1'b0, 8'h00);
    print_verdict();
  end
endmodule : test_adc_sample_output_stage
